// ---- hw/pbs_pkg.sv ----
package pbs_pkg;
  localparam logic [3:0] CMD_MRD = 4'h6;
  localparam logic [3:0] CMD_MWR = 4'h7;
  localparam logic [3:0] CMD_MRDM = 4'hc;
  localparam logic [3:0] CMD_MRDL = 4'he;
  localparam logic [3:0] CMD_MWRI = 4'hf;
  localparam logic [3:0] BE_ALL_N = 4'h0;
  localparam logic [31:0] DW_MASK = 32'hffff_fffc;
  localparam logic [31:0] DEV_BASE = 32'h1000_0000;
  localparam logic [31:0] HOST_BASE = 32'h0000_0000;
  localparam int WIN_BITS = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 36;
  // Clocks without DEVSEL before a master gives up
  localparam int ABORT_CYC = 5;
  // One driven-high clock plus one floating clock
  localparam int IDLE_CYC = 2;
  // Weak pull-up may take this long to lift a wired-OR line
  localparam int PULLUP_RISE_CYC = 3;
  localparam logic [1:0] ZERO2 = 2'h0;

  typedef struct packed {
    logic [31:0] ad;
    logic ad_oe;
    logic [3:0] cbe;
    logic cbe_oe;
    logic par;
    logic par_oe;
    logic frame_n;
    logic irdy_n;
    logic mst_oe;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
    logic tgt_oe;
    logic req_n;
    logic req_oe;
  } pbs_drv_t;

  typedef struct packed {
    logic [31:0] ad;
    logic [3:0] cbe;
    logic par;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
  } pbs_bus_t;
endpackage

// ---- hw/pbs_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pbs_bus_if;
  pbs_pkg::pbs_drv_t dev;
  pbs_pkg::pbs_drv_t hst;
  pbs_pkg::pbs_bus_t bus;
  logic dev_req_n;
  logic gnt_n;
  logic lock_n;
  logic attn_oe;
  logic attn_n;

  // Floating lines rest high on their pull-ups
  always_comb begin
    bus.ad = dev.ad_oe ? dev.ad : (hst.ad_oe ? hst.ad : 32'hffff_ffff);
    bus.cbe = dev.cbe_oe ? dev.cbe : (hst.cbe_oe ? hst.cbe : 4'hf);
    bus.par = dev.par_oe ? dev.par : (hst.par_oe ? hst.par : 1'b1);
    bus.frame_n = dev.mst_oe ? dev.frame_n :
                  (hst.mst_oe ? hst.frame_n : 1'b1);
    bus.irdy_n = dev.mst_oe ? dev.irdy_n : (hst.mst_oe ? hst.irdy_n : 1'b1);
    bus.trdy_n = dev.tgt_oe ? dev.trdy_n : (hst.tgt_oe ? hst.trdy_n : 1'b1);
    bus.devsel_n = dev.tgt_oe ? dev.devsel_n :
                   (hst.tgt_oe ? hst.devsel_n : 1'b1);
    bus.stop_n = dev.tgt_oe ? dev.stop_n : (hst.tgt_oe ? hst.stop_n : 1'b1);
    dev_req_n = dev.req_oe ? dev.req_n : 1'b1;
    attn_n = ~attn_oe;
  end

  modport dev_mp (output dev, attn_oe, input bus, gnt_n, lock_n);
  modport hst_mp (output hst, gnt_n, lock_n, input bus, dev_req_n, attn_n);
endinterface
`default_nettype wire

// ---- hw/pbs_dev.sv ----
// Summary of operation
// RQ1: Drive sustained line high before floating it
// RQ2: Wait one idle clock before driving released line
// RQ3: Wired-OR line may take three clocks rising
// RQ4: Float all bus outputs while reset asserted
// RQ5: Address phase carries 32-bit address, frame low
// RQ6: Lane zero least significant, lane three most
// RQ7: C/BE carries command, then byte enables
// RQ8: Enable bit n qualifies byte lane n
// RQ9: Parity makes AD, C/BE, PAR ones even
// RQ10: Parity valid one clock after its phase
// RQ11: Parity holds until one clock after completion
// RQ12: Master drives addr/write parity, target read
// RQ13: Frame low until final data phase reached
// RQ14: Data phase ends when IRDY, TRDY low
// RQ15: Sample every bus line on rising clock
// RQ16: State reinitialised when reset is released
// RQ17: Drive TRDY as target, sample as master
// RQ18: No locking; lock input ignored
// RQ19: Claim only standard memory command encodings
`timescale 1ns/1ps
`default_nettype none
module pbs_fifo #(
  parameter int W = pbs_pkg::FIFO_W,
  parameter int DEPTH = pbs_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rp_r];

  always_comb begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt = wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = rp_r + 1'b1;
    end
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    mem_r <= mem_nxt;
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

module pbs_dev #(
  parameter logic [31:0] BASE = pbs_pkg::DEV_BASE,
  parameter int WIN_BITS = pbs_pkg::WIN_BITS,
  parameter int FIFO_DEPTH = pbs_pkg::FIFO_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  pbs_bus_if.dev_mp PCI,
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic [31:0] RX_DATA,
  output logic [3:0] RX_BE,
  input wire logic [31:0] RD_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire logic [31:0] TX_DATA,
  input wire logic TX_LAST,
  input wire logic [31:0] TX_ADDR,
  output logic MST_ABORT
);
  typedef enum logic [2:0] {T_IDLE, T_WR, T_RTA, T_RD, T_END} pbs_tst_t;
  typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_END} pbs_mst_t;

  pbs_pkg::pbs_bus_t b;
  pbs_tst_t t_st_r, t_st_nxt;
  pbs_mst_t m_st_r, m_st_nxt;
  logic t_oe_r, t_oe_nxt, t_trdy_r, t_trdy_nxt, t_dev_r, t_dev_nxt;
  logic t_ad_oe_r, t_ad_oe_nxt;
  logic [31:0] t_ad_r, t_ad_nxt, m_ad_r, m_ad_nxt, ad_w;
  logic m_oe_r, m_oe_nxt, m_frame_r, m_frame_nxt, m_irdy_r, m_irdy_nxt;
  logic m_ad_oe_r, m_ad_oe_nxt, m_cbe_oe_r, m_cbe_oe_nxt;
  logic [3:0] m_cbe_r, m_cbe_nxt;
  logic m_seen_r, m_seen_nxt, abort_r, abort_nxt, req_r, req_nxt;
  logic [2:0] m_cnt_r, m_cnt_nxt;
  logic par_r, par_oe_r, frame_q_r, attn_r;
  logic [1:0] idle_r, idle_nxt;
  logic addr_ph, hit, is_wr, is_rd, t_done, m_done, m_take, push, room;
  logic [35:0] push_data, pop_data;

  assign b = PCI.bus; // RQ15
  assign addr_ph = ~b.frame_n & frame_q_r; // RQ5
  assign hit = b.ad[31:WIN_BITS] == BASE[31:WIN_BITS];
  assign is_wr = b.cbe == pbs_pkg::CMD_MWR |
                 b.cbe == pbs_pkg::CMD_MWRI; // RQ19
  assign is_rd = b.cbe == pbs_pkg::CMD_MRD | b.cbe == pbs_pkg::CMD_MRDM |
                 b.cbe == pbs_pkg::CMD_MRDL; // RQ19
  assign t_done = ~b.irdy_n & ~t_trdy_r & t_oe_r; // RQ14
  assign m_done = ~b.trdy_n & ~m_irdy_r & m_oe_r; // RQ17
  assign push = t_st_r == T_WR & t_done;
  assign ad_w = t_ad_oe_r ? t_ad_r : m_ad_r;

  // Disabled lanes are stored as zero
  always_comb begin
    push_data = {~b.cbe, b.ad}; // RQ6
    for (int i = 0; i < 4; i++) begin
      if (b.cbe[i]) begin
        push_data[8*i +: 8] = 8'h00; // RQ8
      end
    end
  end

  pbs_fifo #(.W(pbs_pkg::FIFO_W), .DEPTH(FIFO_DEPTH)) pbs_fifo_inst (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .in_valid(push),
    .in_ready(room),
    .in_data(push_data),
    .out_valid(RX_VALID),
    .out_ready(RX_READY),
    .out_data(pop_data)
  );
  assign RX_DATA = pop_data[31:0];
  assign RX_BE = pop_data[35:32];

  // Target side; LOCK is never looked at RQ18
  always_comb begin
    t_st_nxt = t_st_r;
    t_oe_nxt = t_oe_r;
    t_trdy_nxt = t_trdy_r;
    t_dev_nxt = t_dev_r;
    t_ad_oe_nxt = t_ad_oe_r;
    t_ad_nxt = t_ad_r;
    case (t_st_r)
      T_IDLE: begin
        if (addr_ph & hit & m_st_r == M_IDLE & (is_wr | is_rd)) begin
          t_st_nxt = is_wr ? T_WR : T_RTA;
          t_oe_nxt = 1'b1;
          t_dev_nxt = 1'b0;
          t_trdy_nxt = is_wr ? ~room : 1'b1;
        end
      end
      T_WR: begin
        // One wait after each word keeps the room test exact
        t_trdy_nxt = t_done | ~room;
        if (t_done & b.frame_n) begin
          t_st_nxt = T_END; // RQ13
          t_dev_nxt = 1'b1;
        end
      end
      T_RTA: begin
        t_st_nxt = T_RD; // RQ2
        t_ad_oe_nxt = 1'b1;
        t_ad_nxt = RD_DATA;
        t_trdy_nxt = 1'b0;
      end
      T_RD: begin
        if (t_done) begin
          t_ad_nxt = RD_DATA;
          if (b.frame_n) begin
            t_st_nxt = T_END;
            t_trdy_nxt = 1'b1;
            t_dev_nxt = 1'b1;
            t_ad_oe_nxt = 1'b0;
          end
        end
      end
      default: begin
        t_st_nxt = T_IDLE; // RQ1
        t_oe_nxt = 1'b0;
      end
    endcase
  end

  // Master side: memory write burst fed from the TX stream
  always_comb begin
    m_st_nxt = m_st_r;
    m_oe_nxt = m_oe_r;
    m_frame_nxt = m_frame_r;
    m_irdy_nxt = m_irdy_r;
    m_ad_oe_nxt = m_ad_oe_r;
    m_ad_nxt = m_ad_r;
    m_cbe_oe_nxt = m_cbe_oe_r;
    m_cbe_nxt = m_cbe_r;
    m_seen_nxt = m_seen_r | ~b.devsel_n;
    m_cnt_nxt = m_cnt_r;
    abort_nxt = 1'b0;
    m_take = 1'b0;
    idle_nxt = idle_r;
    if (~b.frame_n | ~b.irdy_n) begin
      idle_nxt = pbs_pkg::ZERO2;
    end else if (idle_r != 2'(pbs_pkg::IDLE_CYC)) begin
      idle_nxt = idle_r + 1'b1;
    end
    case (m_st_r)
      M_IDLE: begin
        if (TX_VALID & ~PCI.gnt_n & t_st_r == T_IDLE &
            idle_r == 2'(pbs_pkg::IDLE_CYC)) begin // RQ2
          m_st_nxt = M_ADDR;
          m_oe_nxt = 1'b1;
          m_frame_nxt = 1'b0; // RQ13
          m_irdy_nxt = 1'b1;
          m_ad_oe_nxt = 1'b1;
          m_ad_nxt = TX_ADDR & pbs_pkg::DW_MASK; // RQ5
          m_cbe_oe_nxt = 1'b1;
          m_cbe_nxt = pbs_pkg::CMD_MWR; // RQ7
          m_seen_nxt = 1'b0;
          m_cnt_nxt = 3'h0;
        end
      end
      M_ADDR: begin
        m_st_nxt = M_DATA;
        m_cbe_nxt = pbs_pkg::BE_ALL_N; // RQ7
        m_take = TX_VALID;
      end
      M_DATA: begin
        if (~m_seen_r) begin
          m_cnt_nxt = m_cnt_r + 3'h1;
        end
        if (m_done & m_frame_r) begin
          m_st_nxt = M_END;
        end else if (~m_seen_r & m_cnt_r == 3'(pbs_pkg::ABORT_CYC)) begin
          m_st_nxt = M_END;
          m_frame_nxt = 1'b1;
          abort_nxt = 1'b1;
        end else if (m_done | m_irdy_r) begin
          m_take = TX_VALID;
          m_irdy_nxt = 1'b1;
        end
        if (m_st_nxt == M_END) begin
          m_irdy_nxt = 1'b1;
          m_ad_oe_nxt = 1'b0;
          m_cbe_oe_nxt = 1'b0;
        end
      end
      default: begin
        m_st_nxt = M_IDLE; // RQ1
        m_oe_nxt = 1'b0;
      end
    endcase
    if (m_take) begin
      m_ad_nxt = TX_DATA; // RQ6
      m_irdy_nxt = 1'b0;
      m_frame_nxt = TX_LAST; // RQ13
    end
    req_nxt = (m_st_r == M_IDLE & TX_VALID) | m_st_r == M_ADDR |
              m_st_r == M_DATA;
  end
  assign TX_READY = m_take;

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin // RQ16
      t_st_r <= T_IDLE;
      t_oe_r <= 1'b0;
      t_trdy_r <= 1'b1;
      t_dev_r <= 1'b1;
      t_ad_oe_r <= 1'b0;
      t_ad_r <= 32'h0000_0000;
      m_st_r <= M_IDLE;
      m_oe_r <= 1'b0;
      m_frame_r <= 1'b1;
      m_irdy_r <= 1'b1;
      m_ad_oe_r <= 1'b0;
      m_ad_r <= 32'h0000_0000;
      m_cbe_oe_r <= 1'b0;
      m_cbe_r <= 4'hf;
      m_seen_r <= 1'b0;
      m_cnt_r <= 3'h0;
      abort_r <= 1'b0;
      req_r <= 1'b0;
      par_r <= 1'b0;
      par_oe_r <= 1'b0;
      frame_q_r <= 1'b1;
      idle_r <= pbs_pkg::ZERO2;
      attn_r <= 1'b0;
    end else begin
      t_st_r <= t_st_nxt;
      t_oe_r <= t_oe_nxt;
      t_trdy_r <= t_trdy_nxt;
      t_dev_r <= t_dev_nxt;
      t_ad_oe_r <= t_ad_oe_nxt;
      t_ad_r <= t_ad_nxt;
      m_st_r <= m_st_nxt;
      m_oe_r <= m_oe_nxt;
      m_frame_r <= m_frame_nxt;
      m_irdy_r <= m_irdy_nxt;
      m_ad_oe_r <= m_ad_oe_nxt;
      m_ad_r <= m_ad_nxt;
      m_cbe_oe_r <= m_cbe_oe_nxt;
      m_cbe_r <= m_cbe_nxt;
      m_seen_r <= m_seen_nxt;
      m_cnt_r <= m_cnt_nxt;
      abort_r <= abort_nxt;
      req_r <= req_nxt;
      // Parity trails the AD it covers by one clock RQ10 RQ11
      par_r <= ^{ad_w, b.cbe}; // RQ9
      par_oe_r <= t_ad_oe_r | m_ad_oe_r; // RQ12
      frame_q_r <= b.frame_n;
      idle_r <= idle_nxt;
      attn_r <= RX_VALID; // RQ3
    end
  end

  // Gating with reset floats the pins at once, not at the next edge
  always_comb begin
    PCI.dev.ad = ad_w;
    PCI.dev.ad_oe = (t_ad_oe_r | m_ad_oe_r) & RESETN; // RQ4
    PCI.dev.cbe = m_cbe_r;
    PCI.dev.cbe_oe = m_cbe_oe_r & RESETN;
    PCI.dev.par = par_r;
    PCI.dev.par_oe = par_oe_r & RESETN;
    PCI.dev.frame_n = m_frame_r;
    PCI.dev.irdy_n = m_irdy_r;
    PCI.dev.mst_oe = m_oe_r & RESETN;
    PCI.dev.trdy_n = t_trdy_r; // RQ17
    PCI.dev.devsel_n = t_dev_r;
    PCI.dev.stop_n = 1'b1;
    PCI.dev.tgt_oe = t_oe_r & RESETN;
    PCI.dev.req_n = ~req_r;
    PCI.dev.req_oe = RESETN;
  end
  assign PCI.attn_oe = attn_r & RESETN;
  assign MST_ABORT = abort_r;
endmodule
`default_nettype wire

// ---- hw/pbs_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module pbs_host #(
  parameter logic [31:0] BASE = pbs_pkg::HOST_BASE,
  parameter int WIN_BITS = pbs_pkg::WIN_BITS
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  pbs_bus_if.hst_mp PCI,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_WRITE,
  input wire logic [31:0] CMD_ADDR,
  input wire logic [31:0] CMD_DATA,
  input wire logic [3:0] CMD_BE,
  output logic RSP_VALID,
  output logic RSP_ABORT,
  output logic [31:0] RSP_DATA,
  output logic RX_VALID,
  output logic [31:0] RX_DATA,
  output logic [3:0] RX_BE,
  output logic ATTN
);
  typedef enum logic [1:0] {H_IDLE, H_ADDR, H_DATA, H_END} pbs_hst_t;
  typedef enum logic [1:0] {HT_IDLE, HT_DATA, HT_END} pbs_htg_t;

  pbs_pkg::pbs_bus_t b;
  pbs_hst_t st_r, st_nxt;
  pbs_htg_t tg_r, tg_nxt;
  logic oe_r, oe_nxt, frame_r, frame_nxt, irdy_r, irdy_nxt, wr_r, wr_nxt;
  logic ad_oe_r, ad_oe_nxt, cbe_oe_r, cbe_oe_nxt, seen_r, seen_nxt;
  logic [31:0] ad_r, ad_nxt, data_r, data_nxt, rsp_r, rsp_nxt;
  logic [31:0] rx_r, rx_nxt;
  logic [3:0] cbe_r, cbe_nxt, be_r, be_nxt, rxbe_r, rxbe_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [1:0] idle_r, idle_nxt, hi_r, hi_nxt;
  logic tgo_r, tgo_nxt, tsel_r, tsel_nxt, rxv_r, rxv_nxt;
  logic rv_r, rv_nxt, ab_r, ab_nxt, gnt_r, gnt_nxt, attn_r, attn_nxt;
  logic par_r, par_oe_r, frame_q_r, start, done;

  assign b = PCI.bus;
  assign start = st_r == H_IDLE & CMD_VALID & gnt_r & PCI.dev_req_n &
                 tg_r == HT_IDLE & idle_r == 2'(pbs_pkg::IDLE_CYC);
  assign done = ~b.trdy_n & ~irdy_r & oe_r; // RQ14
  assign CMD_READY = start;

  always_comb begin
    st_nxt = st_r;
    oe_nxt = oe_r;
    frame_nxt = frame_r;
    irdy_nxt = irdy_r;
    wr_nxt = wr_r;
    ad_oe_nxt = ad_oe_r;
    ad_nxt = ad_r;
    cbe_oe_nxt = cbe_oe_r;
    cbe_nxt = cbe_r;
    data_nxt = data_r;
    be_nxt = be_r;
    seen_nxt = seen_r | ~b.devsel_n;
    cnt_nxt = cnt_r;
    rv_nxt = 1'b0;
    ab_nxt = 1'b0;
    rsp_nxt = rsp_r;
    idle_nxt = idle_r;
    if (~b.frame_n | ~b.irdy_n) begin
      idle_nxt = pbs_pkg::ZERO2;
    end else if (idle_r != 2'(pbs_pkg::IDLE_CYC)) begin
      idle_nxt = idle_r + 1'b1;
    end
    case (st_r)
      H_IDLE: begin
        if (start) begin // RQ2
          st_nxt = H_ADDR;
          oe_nxt = 1'b1;
          frame_nxt = 1'b0; // RQ5
          ad_oe_nxt = 1'b1;
          ad_nxt = CMD_ADDR & pbs_pkg::DW_MASK;
          cbe_oe_nxt = 1'b1;
          cbe_nxt = CMD_WRITE ? pbs_pkg::CMD_MWR : pbs_pkg::CMD_MRD; // RQ7
          wr_nxt = CMD_WRITE;
          data_nxt = CMD_DATA;
          be_nxt = ~CMD_BE; // RQ8
          seen_nxt = 1'b0;
          cnt_nxt = 3'h0;
        end
      end
      H_ADDR: begin
        // Single data phase, so FRAME rises with IRDY
        st_nxt = H_DATA;
        frame_nxt = 1'b1;
        irdy_nxt = 1'b0;
        cbe_nxt = be_r; // RQ7
        ad_nxt = data_r;
        ad_oe_nxt = wr_r; // RQ2
      end
      H_DATA: begin
        if (~seen_r) begin
          cnt_nxt = cnt_r + 3'h1;
        end
        if (done | (~seen_r & cnt_r == 3'(pbs_pkg::ABORT_CYC))) begin
          st_nxt = H_END;
          irdy_nxt = 1'b1;
          ad_oe_nxt = 1'b0;
          cbe_oe_nxt = 1'b0;
          rv_nxt = 1'b1;
          ab_nxt = ~done;
          rsp_nxt = b.ad;
        end
      end
      default: begin
        st_nxt = H_IDLE; // RQ1
        oe_nxt = 1'b0;
      end
    endcase
    // Device gets the bus only while this master is idle
    gnt_nxt = gnt_r ? ~(~PCI.dev_req_n & st_r == H_IDLE & ~start) :
              PCI.dev_req_n;
  end

  // Target for device-mastered memory writes only
  always_comb begin
    tg_nxt = tg_r;
    tgo_nxt = tgo_r;
    tsel_nxt = tsel_r;
    rxv_nxt = 1'b0;
    rx_nxt = rx_r;
    rxbe_nxt = rxbe_r;
    case (tg_r)
      HT_IDLE: begin
        if (~b.frame_n & frame_q_r & st_r == H_IDLE &
            b.ad[31:WIN_BITS] == BASE[31:WIN_BITS] &
            (b.cbe == pbs_pkg::CMD_MWR | b.cbe == pbs_pkg::CMD_MWRI)) begin
          tg_nxt = HT_DATA;
          tgo_nxt = 1'b1;
          tsel_nxt = 1'b0;
        end
      end
      HT_DATA: begin
        if (~b.irdy_n) begin // RQ14
          rxv_nxt = 1'b1;
          rxbe_nxt = ~b.cbe;
          for (int i = 0; i < 4; i++) begin
            rx_nxt[8*i +: 8] = b.cbe[i] ? 8'h00 : b.ad[8*i +: 8]; // RQ8
          end
          if (b.frame_n) begin
            tg_nxt = HT_END;
            tsel_nxt = 1'b1;
          end
        end
      end
      default: begin
        tg_nxt = HT_IDLE; // RQ1
        tgo_nxt = 1'b0;
      end
    endcase
    // Only a long enough run of high samples counts as release
    hi_nxt = hi_r;
    attn_nxt = attn_r;
    if (~PCI.attn_n) begin
      hi_nxt = pbs_pkg::ZERO2;
      attn_nxt = 1'b1;
    end else if (hi_r == 2'(pbs_pkg::PULLUP_RISE_CYC - 1)) begin
      attn_nxt = 1'b0; // RQ3
    end else begin
      hi_nxt = hi_r + 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      st_r <= H_IDLE;
      tg_r <= HT_IDLE;
      oe_r <= 1'b0;
      frame_r <= 1'b1;
      irdy_r <= 1'b1;
      wr_r <= 1'b0;
      ad_oe_r <= 1'b0;
      ad_r <= 32'h0000_0000;
      cbe_oe_r <= 1'b0;
      cbe_r <= 4'hf;
      data_r <= 32'h0000_0000;
      be_r <= 4'hf;
      seen_r <= 1'b0;
      cnt_r <= 3'h0;
      rv_r <= 1'b0;
      ab_r <= 1'b0;
      rsp_r <= 32'h0000_0000;
      idle_r <= pbs_pkg::ZERO2;
      gnt_r <= 1'b1;
      tgo_r <= 1'b0;
      tsel_r <= 1'b1;
      rxv_r <= 1'b0;
      rx_r <= 32'h0000_0000;
      rxbe_r <= 4'h0;
      hi_r <= pbs_pkg::ZERO2;
      attn_r <= 1'b0;
      par_r <= 1'b0;
      par_oe_r <= 1'b0;
      frame_q_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      tg_r <= tg_nxt;
      oe_r <= oe_nxt;
      frame_r <= frame_nxt;
      irdy_r <= irdy_nxt;
      wr_r <= wr_nxt;
      ad_oe_r <= ad_oe_nxt;
      ad_r <= ad_nxt;
      cbe_oe_r <= cbe_oe_nxt;
      cbe_r <= cbe_nxt;
      data_r <= data_nxt;
      be_r <= be_nxt;
      seen_r <= seen_nxt;
      cnt_r <= cnt_nxt;
      rv_r <= rv_nxt;
      ab_r <= ab_nxt;
      rsp_r <= rsp_nxt;
      idle_r <= idle_nxt;
      gnt_r <= gnt_nxt;
      tgo_r <= tgo_nxt;
      tsel_r <= tsel_nxt;
      rxv_r <= rxv_nxt;
      rx_r <= rx_nxt;
      rxbe_r <= rxbe_nxt;
      hi_r <= hi_nxt;
      attn_r <= attn_nxt;
      par_r <= ^{ad_r, b.cbe}; // RQ9 RQ10 RQ11
      par_oe_r <= ad_oe_r;
      frame_q_r <= b.frame_n;
    end
  end

  always_comb begin
    PCI.hst.ad = ad_r;
    PCI.hst.ad_oe = ad_oe_r & RESETN;
    PCI.hst.cbe = cbe_r;
    PCI.hst.cbe_oe = cbe_oe_r & RESETN;
    PCI.hst.par = par_r;
    PCI.hst.par_oe = par_oe_r & RESETN;
    PCI.hst.frame_n = frame_r;
    PCI.hst.irdy_n = irdy_r;
    PCI.hst.mst_oe = oe_r & RESETN;
    PCI.hst.trdy_n = tsel_r;
    PCI.hst.devsel_n = tsel_r;
    PCI.hst.stop_n = 1'b1;
    PCI.hst.tgt_oe = tgo_r & RESETN;
    PCI.hst.req_n = 1'b1;
    PCI.hst.req_oe = 1'b0;
  end
  assign PCI.gnt_n = gnt_r;
  assign PCI.lock_n = 1'b1;
  assign RSP_VALID = rv_r;
  assign RSP_ABORT = ab_r;
  assign RSP_DATA = rsp_r;
  assign RX_VALID = rxv_r;
  assign RX_DATA = rx_r;
  assign RX_BE = rxbe_r;
  assign ATTN = attn_r;
endmodule
`default_nettype wire

// ---- bench/pbs_bus_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module pbs_bus_checker (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire pbs_pkg::pbs_drv_t dev,
  input wire pbs_pkg::pbs_drv_t hst,
  input wire pbs_pkg::pbs_bus_t bus
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  sequence dev_wr_addr;
    $fell(bus.frame_n) && bus.cbe == pbs_pkg::CMD_MWR &&
      bus.ad[31:12] == 20'h10000;
  endsequence
  sequence hst_stalled;
    hst.mst_oe && !hst.irdy_n && bus.trdy_n && !bus.devsel_n;
  endsequence
  // Reset is the cause here, so it cannot also disable the check
  a_reset_float: assert property (disable iff (1'b0)
    !RESETN |-> !(dev.ad_oe | dev.cbe_oe | dev.par_oe | dev.mst_oe |
    dev.tgt_oe | dev.req_oe)) else $error("bus driven in reset");
  a_mst_park_high: assert property (
    $fell(dev.mst_oe) |-> $past(dev.frame_n) && $past(dev.irdy_n))
    else $error("master line floated low");
  a_tgt_park_high: assert property (
    $fell(hst.tgt_oe) |-> $past(hst.trdy_n & hst.devsel_n))
    else $error("target line floated low");
  a_ad_turnaround: assert property (
    $rose(dev.ad_oe) |-> !$past(hst.ad_oe)) else $error("ad overlap");
  a_dev_parity: assert property (
    dev.par_oe |-> dev.par == ^{$past(bus.ad), $past(bus.cbe)})
    else $error("bad parity");
  a_hst_parity: assert property (
    hst.par_oe |-> hst.par == ^{$past(bus.ad), $past(bus.cbe)})
    else $error("bad host parity");
  a_par_owner: assert property (
    dev.par_oe |-> $past(dev.ad_oe)) else $error("foreign parity");
  a_frame_last: assert property (
    dev.mst_oe && $rose(dev.frame_n) && !bus.devsel_n |-> !dev.irdy_n)
    else $error("frame ended early");
  a_wait_hold: assert property (
    hst_stalled |=> !hst.irdy_n && $stable(bus.cbe) &&
    (!$past(hst.ad_oe) || $stable(bus.ad)))
    else $error("phase left before ready");
  a_dev_claim: assert property (
    dev_wr_addr |=> !bus.devsel_n ##0 dev.tgt_oe)
    else $error("write not claimed");
  a_mst_addr: assert property (
    $fell(bus.frame_n) && dev.mst_oe |->
    bus.cbe == pbs_pkg::CMD_MWR && bus.ad[1:0] == pbs_pkg::ZERO2)
    else $error("bad address phase");
endmodule
`default_nettype wire

// ---- bench/tb_pci_bus_signal_phasing.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_pci_bus_signal_phasing;
  logic clk_sys, resetn, d_rx_valid, d_rx_ready, d_tx_valid, d_tx_ready;
  logic d_tx_last, d_abort, c_valid, c_ready, c_write, r_valid, r_abort;
  logic h_rx_valid, attn, ab;
  logic [31:0] d_rx_data, d_rd_data, d_tx_data, d_tx_addr, c_addr, c_data;
  logic [31:0] r_data, h_rx_data, got;
  logic [3:0] d_rx_be, c_be, h_rx_be;
  logic [35:0] hq[$];
  int mismatches, checks;
  pbs_bus_if pci ();
  pbs_dev pbs_dev_inst (.CLK_SYS(clk_sys), .RESETN(resetn), .PCI(pci.dev_mp),
    .RX_VALID(d_rx_valid), .RX_READY(d_rx_ready), .RX_DATA(d_rx_data),
    .RX_BE(d_rx_be), .RD_DATA(d_rd_data), .TX_VALID(d_tx_valid),
    .TX_READY(d_tx_ready), .TX_DATA(d_tx_data), .TX_LAST(d_tx_last),
    .TX_ADDR(d_tx_addr), .MST_ABORT(d_abort));
  pbs_host pbs_host_inst (.CLK_SYS(clk_sys), .RESETN(resetn),
    .PCI(pci.hst_mp), .CMD_VALID(c_valid), .CMD_READY(c_ready),
    .CMD_WRITE(c_write), .CMD_ADDR(c_addr), .CMD_DATA(c_data),
    .CMD_BE(c_be), .RSP_VALID(r_valid), .RSP_ABORT(r_abort),
    .RSP_DATA(r_data), .RX_VALID(h_rx_valid), .RX_DATA(h_rx_data),
    .RX_BE(h_rx_be), .ATTN(attn));
  pbs_bus_checker pbs_bus_checker_inst (.CLK_SYS(clk_sys), .RESETN(resetn),
    .dev(pci.dev), .hst(pci.hst), .bus(pci.bus));

  task automatic final_report;
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_hi(ref logic s);
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (s !== 1'b1 && i < 300);
    if (s !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic host_op(input logic w, input logic [31:0] a, d,
                         input logic [3:0] be);
    c_write = w;
    c_addr = a;
    c_data = d;
    c_be = be;
    c_valid = 1'b1;
    wait_hi(c_ready);
    #1 c_valid = 1'b0;
    wait_hi(r_valid);
    got = r_data;
    ab = r_abort;
    #1;
  endtask
  task automatic rx_pop(output logic [35:0] v);
    wait_hi(d_rx_valid);
    #1 d_rx_ready = 1'b1;
    @(posedge clk_sys);
    v = {d_rx_be, d_rx_data};
    #1 d_rx_ready = 1'b0;
  endtask
  function automatic logic [31:0] lanes(input logic [31:0] d,
                                        input logic [3:0] be);
    lanes = 32'h0;
    for (int i = 0; i < 4; i++) if (be[i]) lanes[8*i +: 8] = d[8*i +: 8];
  endfunction
  function automatic logic [3:0] be_of(input int k);
    logic [3:0] t[4] = '{4'hf, 4'h1, 4'h8, 4'h6};
    be_of = t[k % 4];
  endfunction

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (h_rx_valid === 1'b1) begin
    hq.push_back({h_rx_be, h_rx_data});
  end

  initial begin
    logic [35:0] v;
    int k;
    resetn = 1'b0;
    d_rx_ready = 1'b0;
    d_tx_valid = 1'b0;
    d_tx_last = 1'b0;
    c_valid = 1'b0;
    c_write = 1'b0;
    c_be = 4'h0;
    d_rd_data = 32'h0;
    d_tx_data = 32'h0;
    d_tx_addr = 32'h0;
    c_addr = 32'h0;
    c_data = 32'h0;
    repeat (16) @(posedge clk_sys);
    `CHK({pci.dev.ad_oe, pci.dev.mst_oe, pci.dev.tgt_oe}, 3'h0)
    #1 resetn = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    for (k = 0; k < 16; k++) begin
      host_op(1'b1, 32'h1000_0000 + 4 * k, 32'h1122_3344 ^ k, be_of(k));
      `CHK(ab, 1'b0)
    end
    `CHK(attn, 1'b1)
    fork
      host_op(1'b1, 32'h1000_0040, 32'hcafe_f00d, 4'hf);
      begin
        repeat (20) @(posedge clk_sys);
        `CHK({pci.bus.irdy_n, pci.bus.trdy_n}, 2'h1)
        #1;
        for (k = 0; k < 16; k++) begin
          rx_pop(v);
          `CHK(v, {be_of(k), lanes(32'h1122_3344 ^ k, be_of(k))})
        end
        rx_pop(v);
        `CHK(v, {4'hf, 32'hcafe_f00d})
      end
    join
    // Flag must outlast a slow pull-up: three high samples first
    repeat (3) @(posedge clk_sys);
    `CHK(attn, 1'b1)
    repeat (3) @(posedge clk_sys);
    `CHK(attn, 1'b0)
    #1 d_rd_data = 32'h8765_4321;
    host_op(1'b0, 32'h1000_0010, 32'h0, 4'hf);
    `CHK(got, 32'h8765_4321)
    host_op(1'b0, 32'h2000_0000, 32'h0, 4'hf);
    `CHK(ab, 1'b1)
    for (k = 0; k < 3; k++) begin
      d_tx_valid = 1'b1;
      d_tx_addr = 32'h0000_0103;
      d_tx_data = 32'h5a00_0000 + k;
      d_tx_last = (k == 2);
      wait_hi(d_tx_ready);
      #1;
    end
    d_tx_valid = 1'b0;
    for (k = 0; k < 50 && hq.size() < 3; k++) @(posedge clk_sys);
    `CHK(hq.size(), 3)
    for (k = 0; k < 3; k++) `CHK(hq[k], {4'hf, 32'h5a00_0000 + k})
    #1 d_tx_valid = 1'b1;
    d_tx_addr = 32'h3000_0000;
    d_tx_last = 1'b1;
    wait_hi(d_tx_ready);
    #1 d_tx_valid = 1'b0;
    wait_hi(d_abort);
    `CHK(d_abort, 1'b1)
    #1 d_tx_valid = 1'b1;
    d_tx_addr = 32'h0;
    repeat (3) @(posedge clk_sys);
    #1 resetn = 1'b0;
    d_tx_valid = 1'b0;
    @(posedge clk_sys);
    `CHK({pci.dev.ad_oe, pci.dev.mst_oe, pci.dev.req_oe}, 3'h0)
    #1 resetn = 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK(pci.bus.frame_n, 1'b1)
    final_report();
  end
endmodule
`default_nettype wire
